// ==== fmr_defines.svh ====
`ifndef FMR_DEFINES_SVH
`define FMR_DEFINES_SVH
// Register indices; the byte address is four times the index
`define FMR_IDX_T2_MODE 12'h07d
`define FMR_IDX_T2_RATE 12'h097
`define FMR_IDX_T2_MASK 12'h145
`define FMR_IDX_PLUS_MASK 12'h146
`define FMR_IDX_MINUS_MASK 12'h147
`define FMR_IDX_CMD_SPLIT 12'h14a
`define FMR_IDX_EXT_SPLIT 12'h14b
`define FMR_IDX_STR_SPLIT 12'h14c
`define FMR_IDX_SRV_DELAY 12'h14e
`define FMR_IDX_IRQ_STAT 12'h180
`define FMR_IDX_IRQ_MASK 12'h181
`define FMR_IDX_FAULT 12'h182
// Reset values
`define FMR_RST_T2_MASK 24'h02_9b01
`define FMR_RST_DIR_MASK 24'h00_0100
`define FMR_RST_CMD_SPLIT 24'h00_00fa
`define FMR_RST_EXT_SPLIT 24'h00_0028
`define FMR_RST_STR_SPLIT 24'h00_0028
`define FMR_RST_SRV_DELAY 24'h00_07d0
`define FMR_RST_T2_MODE 2'h0
`define FMR_RST_T2_RATE 24'h00_0000
// Reserved fault bits 10, 22 and 23
`define FMR_RESERVED_BITS 24'hc0_0400
// Pool sizes and split limits
`define FMR_CMD_TOTAL 9'h12c
`define FMR_CMD_MAX 24'h00_012b
`define FMR_BUF_TOTAL 9'h032
`define FMR_BUF_MAX 24'h00_0031
`define FMR_DELAY_MAX 24'h00_2710
// Timing: one millisecond at 100 MHz
`define FMR_CLK_MHZ 100
`define FMR_MS_US 1000
`define FMR_MS_CYCLES (`FMR_CLK_MHZ * `FMR_MS_US)
// Interrupt status bits
`define FMR_IRQ_T2_EXC 0
`define FMR_IRQ_PLUS 1
`define FMR_IRQ_MINUS 2
`define FMR_IRQ_SRV_RST 3
`define FMR_IRQ_POOL 4
`define FMR_IRQ_W 5
`endif

// ==== fmr_pkg.sv ====
package fmr_pkg;
   // Task 2 exception modes
   typedef enum logic [1:0] {
      FMR_MODE_OFF = 2'b00,
      FMR_MODE_HOLD = 2'b01,
      FMR_MODE_EXIT = 2'b10
   } fmr_mode_t;
   // Servo reset delay states
   typedef enum logic [1:0] {
      FMR_DLY_IDLE = 2'b00,
      FMR_DLY_WAIT = 2'b01,
      FMR_DLY_FIRE = 2'b10
   } fmr_dly_t;
   // One compiled command line offered to the pools
   typedef struct packed {
      logic valid;
      logic task2;
      logic has_ref;
      logic has_string;
   } fmr_line_t;
   // Motion request from the trajectory generator
   typedef struct packed {
      logic valid;
      logic positive;
   } fmr_move_t;
endpackage

// ==== fmr_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fmr_defines.svh"
module fmr_top #(
   parameter int MS_CYCLES = `FMR_MS_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Avalon-MM slave, byte address
   input wire logic [13:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Axis fault status and servo timing
   input wire logic [23:0] fault_status_i,
   input wire logic servo_tick_i,
   input wire logic sys_reset_i,
   // Motion request and grant
   input wire fmr_pkg::fmr_move_t move_i,
   output logic move_grant_o,
   // Task 2 exception responses and direction inhibits
   output logic t2_stop_exit_o,
   output logic t2_feedhold_o,
   output logic [23:0] t2_feedhold_rate_o,
   output logic plus_inhibit_o,
   output logic minus_inhibit_o,
   // Buffer pools
   input wire fmr_pkg::fmr_line_t line_i,
   input wire logic [1:0] task_clear_i,
   output logic line_ok_o,
   output logic line_fail_o,
   // Servo loop reset
   output logic servo_hold_o,
   output logic servo_reset_o,
   // Interrupt
   output logic irq_o
);
   import fmr_pkg::*;

   // Register file
   logic [1:0] mode_q, mode_d;
   logic [23:0] rate_q, rate_d;
   logic [23:0] t2_mask_q, t2_mask_d;
   logic [23:0] plus_mask_q, plus_mask_d;
   logic [23:0] minus_mask_q, minus_mask_d;
   logic [23:0] split_q [3];
   logic [23:0] split_d [3];
   logic [23:0] delay_q, delay_d;
   logic [`FMR_IRQ_W-1:0] istat_q, istat_d;
   logic [`FMR_IRQ_W-1:0] imask_q, imask_d;
   logic [31:0] rdata_q, rdata_d;
   logic wait_q, wait_d;
   // Bus access qualifiers
   logic acc_go; // Request completes at this edge
   logic wr_go;
   logic rd_go;
   logic [11:0] widx;
   // Fault response state
   logic t2_hit_q, t2_hit_d; // Masked Task 2 fault active
   logic stop_q, stop_d;
   logic hold_q, hold_d;
   logic plus_q, plus_d;
   logic minus_q, minus_d;
   logic grant_q, grant_d;
   logic [23:0] live; // Fault vector with reserved bits cleared
   logic t2_rise, plus_rise, minus_rise;
   // Servo delay state
   fmr_dly_t dly_q, dly_d;
   logic [23:0] ms_left_q, ms_left_d;
   logic [31:0] pre_q, pre_d;
   logic srv_hold_q, srv_hold_d;
   logic srv_rst_q, srv_rst_d;
   // Pool handshake
   logic [2:0] need; // Pools this line would use
   logic [2:0] full; // Pools exhausted for the line's task
   logic take; // Line accepted
   logic ok_q, fail_q;
   logic irq_q;

   // Completion of a held request
   always_comb begin
      acc_go = (avs_read_i | avs_write_i) & ~wait_q;
      wr_go = acc_go & avs_write_i;
      rd_go = acc_go & avs_read_i;
      widx = avs_address_i[13:2];
   end

   // Reserved bits never take part in any mask response
   always_comb begin
      live = fault_status_i & ~`FMR_RESERVED_BITS;
   end

   // Register writes, read mux and interrupt status
   always_comb begin
      mode_d = mode_q;
      rate_d = rate_q;
      t2_mask_d = t2_mask_q;
      plus_mask_d = plus_mask_q;
      minus_mask_d = minus_mask_q;
      delay_d = delay_q;
      imask_d = imask_q;
      for (int i = 0; i < 3; i++) begin
         split_d[i] = split_q[i];
      end
      // One wait cycle, then the answer
      wait_d = ~((avs_read_i | avs_write_i) & wait_q);
      rdata_d = rdata_q;
      if (wr_go) begin
         // Masks keep all 24 bits; reserved ones are stored but unused
         if (widx == `FMR_IDX_T2_MODE) begin
            if (avs_writedata_i[1:0] != 2'b11) begin
               mode_d = avs_writedata_i[1:0];
            end
         end else if (widx == `FMR_IDX_T2_RATE) begin
            rate_d = avs_writedata_i[23:0];
         end else if (widx == `FMR_IDX_T2_MASK) begin
            t2_mask_d = avs_writedata_i[23:0];
         end else if (widx == `FMR_IDX_PLUS_MASK) begin
            plus_mask_d = avs_writedata_i[23:0];
         end else if (widx == `FMR_IDX_MINUS_MASK) begin
            minus_mask_d = avs_writedata_i[23:0];
         end else if (widx == `FMR_IDX_CMD_SPLIT) begin
            // Out of range shares are ignored
            if (avs_writedata_i[23:0] != 24'h00_0000 &&
                avs_writedata_i[23:0] <= `FMR_CMD_MAX) begin
               split_d[0] = avs_writedata_i[23:0];
            end
         end else if (widx == `FMR_IDX_EXT_SPLIT) begin
            if (avs_writedata_i[23:0] != 24'h00_0000 &&
                avs_writedata_i[23:0] <= `FMR_BUF_MAX) begin
               split_d[1] = avs_writedata_i[23:0];
            end
         end else if (widx == `FMR_IDX_STR_SPLIT) begin
            if (avs_writedata_i[23:0] != 24'h00_0000 &&
                avs_writedata_i[23:0] <= `FMR_BUF_MAX) begin
               split_d[2] = avs_writedata_i[23:0];
            end
         end else if (widx == `FMR_IDX_SRV_DELAY) begin
            if (avs_writedata_i[23:0] != 24'h00_0000 &&
                avs_writedata_i[23:0] <= `FMR_DELAY_MAX) begin
               delay_d = avs_writedata_i[23:0];
            end
         end else if (widx == `FMR_IDX_IRQ_MASK) begin
            imask_d = avs_writedata_i[`FMR_IRQ_W-1:0];
         end
      end
      // Read data is captured while waitrequest is high
      if ((avs_read_i & wait_q) == 1'b1) begin
         if (widx == `FMR_IDX_T2_MODE) begin
            rdata_d = {30'h0000_0000, mode_q};
         end else if (widx == `FMR_IDX_T2_RATE) begin
            rdata_d = {8'h00, rate_q};
         end else if (widx == `FMR_IDX_T2_MASK) begin
            rdata_d = {8'h00, t2_mask_q};
         end else if (widx == `FMR_IDX_PLUS_MASK) begin
            rdata_d = {8'h00, plus_mask_q};
         end else if (widx == `FMR_IDX_MINUS_MASK) begin
            rdata_d = {8'h00, minus_mask_q};
         end else if (widx == `FMR_IDX_CMD_SPLIT) begin
            rdata_d = {8'h00, split_q[0]};
         end else if (widx == `FMR_IDX_EXT_SPLIT) begin
            rdata_d = {8'h00, split_q[1]};
         end else if (widx == `FMR_IDX_STR_SPLIT) begin
            rdata_d = {8'h00, split_q[2]};
         end else if (widx == `FMR_IDX_SRV_DELAY) begin
            rdata_d = {8'h00, delay_q};
         end else if (widx == `FMR_IDX_IRQ_STAT) begin
            rdata_d = {27'h000_0000, istat_q};
         end else if (widx == `FMR_IDX_IRQ_MASK) begin
            rdata_d = {27'h000_0000, imask_q};
         end else if (widx == `FMR_IDX_FAULT) begin
            rdata_d = {8'h00, fault_status_i};
         end else begin
            // Unmapped addresses read as zero
            rdata_d = 32'h0000_0000;
         end
      end
      // Read clears status; a new event in the same cycle still sets
      istat_d = istat_q;
      if (rd_go && widx == `FMR_IDX_IRQ_STAT) begin
         istat_d = '0;
      end
      istat_d[`FMR_IRQ_T2_EXC] = istat_d[`FMR_IRQ_T2_EXC] | t2_rise;
      istat_d[`FMR_IRQ_PLUS] = istat_d[`FMR_IRQ_PLUS] | plus_rise;
      istat_d[`FMR_IRQ_MINUS] = istat_d[`FMR_IRQ_MINUS] | minus_rise;
      istat_d[`FMR_IRQ_SRV_RST] = istat_d[`FMR_IRQ_SRV_RST] | srv_rst_d;
      istat_d[`FMR_IRQ_POOL] = istat_d[`FMR_IRQ_POOL] | (line_i.valid & ~take);
   end

   // Register file and bus flops
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         mode_q <= `FMR_RST_T2_MODE;
         rate_q <= `FMR_RST_T2_RATE;
         t2_mask_q <= `FMR_RST_T2_MASK;
         plus_mask_q <= `FMR_RST_DIR_MASK;
         minus_mask_q <= `FMR_RST_DIR_MASK;
         split_q[0] <= `FMR_RST_CMD_SPLIT;
         split_q[1] <= `FMR_RST_EXT_SPLIT;
         split_q[2] <= `FMR_RST_STR_SPLIT;
         delay_q <= `FMR_RST_SRV_DELAY;
         istat_q <= '0;
         imask_q <= '0;
         rdata_q <= 32'h0000_0000;
         wait_q <= 1'b1;
         irq_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         rate_q <= rate_d;
         t2_mask_q <= t2_mask_d;
         plus_mask_q <= plus_mask_d;
         minus_mask_q <= minus_mask_d;
         split_q <= split_d;
         delay_q <= delay_d;
         istat_q <= istat_d;
         imask_q <= imask_d;
         rdata_q <= rdata_d;
         wait_q <= wait_d;
         irq_q <= |(istat_d & imask_d);
      end
   end

   // Mask responses, sampled on each servo update
   always_comb begin
      t2_hit_d = t2_hit_q;
      plus_d = plus_q;
      minus_d = minus_q;
      if (servo_tick_i) begin
         t2_hit_d = |(live & t2_mask_q);
         plus_d = |(live & plus_mask_q);
         minus_d = |(live & minus_mask_q);
      end
      t2_rise = t2_hit_d & ~t2_hit_q & (mode_q != FMR_MODE_OFF);
      plus_rise = plus_d & ~plus_q;
      minus_rise = minus_d & ~minus_q;
      // Exit is one pulse on a new fault; feedhold lasts while it stands
      stop_d = t2_hit_d & ~t2_hit_q & (mode_q == FMR_MODE_EXIT);
      hold_d = t2_hit_d & (mode_q == FMR_MODE_HOLD);
      // Only the blocked direction is refused
      grant_d = move_i.valid &
                ~(move_i.positive & plus_d) &
                ~(~move_i.positive & minus_d);
   end

   // Mask response flops
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         t2_hit_q <= 1'b0;
         plus_q <= 1'b0;
         minus_q <= 1'b0;
         stop_q <= 1'b0;
         hold_q <= 1'b0;
         grant_q <= 1'b0;
      end else begin
         t2_hit_q <= t2_hit_d;
         plus_q <= plus_d;
         minus_q <= minus_d;
         stop_q <= stop_d;
         hold_q <= hold_d;
         grant_q <= grant_d;
      end
   end

   // Servo loop reset delay after a system reset command
   always_comb begin
      dly_d = dly_q;
      ms_left_d = ms_left_q;
      pre_d = pre_q;
      srv_rst_d = 1'b0;
      case (dly_q)
         FMR_DLY_IDLE: begin
            if (sys_reset_i) begin
               dly_d = FMR_DLY_WAIT;
               ms_left_d = delay_q;
               pre_d = 32'(MS_CYCLES - 1);
            end
         end
         FMR_DLY_WAIT: begin
            // A repeated reset command restarts the wait
            if (sys_reset_i) begin
               ms_left_d = delay_q;
               pre_d = 32'(MS_CYCLES - 1);
            end else if (pre_q != 32'h0000_0000) begin
               pre_d = pre_q - 32'h0000_0001;
            end else if (ms_left_q > 24'h00_0001) begin
               ms_left_d = ms_left_q - 24'h00_0001;
               pre_d = 32'(MS_CYCLES - 1);
            end else begin
               dly_d = FMR_DLY_FIRE;
            end
         end
         FMR_DLY_FIRE: begin
            srv_rst_d = 1'b1;
            dly_d = FMR_DLY_IDLE;
         end
         default: begin
            dly_d = FMR_DLY_IDLE;
         end
      endcase
      srv_hold_d = (dly_d == FMR_DLY_WAIT);
   end

   // Servo delay flops
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         dly_q <= FMR_DLY_IDLE;
         ms_left_q <= 24'h00_0000;
         pre_q <= 32'h0000_0000;
         srv_hold_q <= 1'b0;
         srv_rst_q <= 1'b0;
      end else begin
         dly_q <= dly_d;
         ms_left_q <= ms_left_d;
         pre_q <= pre_d;
         srv_hold_q <= srv_hold_d;
         srv_rst_q <= srv_rst_d;
      end
   end

   // Which pools a compiled line draws from
   always_comb begin
      need[0] = 1'b1;
      need[1] = line_i.has_ref;
      need[2] = line_i.has_string;
      take = line_i.valid & ~|(need & full);
   end

   // Per pool usage counters for both tasks
   genvar gp;
   generate
      for (gp = 0; gp < 3; gp++) begin : g_pool
         logic [8:0] total;
         logic [8:0] lim1, lim2;
         logic [8:0] used1_q, used1_d, used2_q, used2_d;
         always_comb begin
            total = (gp == 0) ? `FMR_CMD_TOTAL : `FMR_BUF_TOTAL;
            lim1 = split_q[gp][8:0];
            lim2 = total - lim1;
            full[gp] = line_i.task2 ? (used2_q >= lim2) : (used1_q >= lim1);
            used1_d = task_clear_i[0] ? 9'h000 : used1_q;
            used2_d = task_clear_i[1] ? 9'h000 : used2_q;
            if (take && need[gp]) begin
               if (line_i.task2) begin
                  used2_d = used2_q + 9'h001;
               end else begin
                  used1_d = used1_q + 9'h001;
               end
            end
         end
         always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
               used1_q <= 9'h000;
               used2_q <= 9'h000;
            end else begin
               used1_q <= used1_d;
               used2_q <= used2_d;
            end
         end
      end
   endgenerate

   // Line answer flops
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ok_q <= 1'b0;
         fail_q <= 1'b0;
      end else begin
         ok_q <= take;
         fail_q <= line_i.valid & ~take;
      end
   end

   // Outputs straight from flops
   assign avs_readdata_o = rdata_q;
   assign avs_waitrequest_o = wait_q;
   assign move_grant_o = grant_q;
   assign t2_stop_exit_o = stop_q;
   assign t2_feedhold_o = hold_q;
   assign t2_feedhold_rate_o = rate_q;
   assign plus_inhibit_o = plus_q;
   assign minus_inhibit_o = minus_q;
   assign line_ok_o = ok_q;
   assign line_fail_o = fail_q;
   assign servo_hold_o = srv_hold_q;
   assign servo_reset_o = srv_rst_q;
   assign irq_o = irq_q;

   // Checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_t2_exc_raise: assert property ((servo_tick_i && |(live & t2_mask_q) && !t2_hit_q
      && mode_q == FMR_MODE_EXIT) |=> t2_stop_exit_o) else $error("no exit pulse");
   a_exit_single: assert property (t2_stop_exit_o |=> !t2_stop_exit_o)
      else $error("exit held");
   a_hold_mode: assert property (t2_feedhold_o |-> $past(mode_q) == FMR_MODE_HOLD)
      else $error("feedhold outside hold mode");
   a_off_quiet: assert property ((mode_q == FMR_MODE_OFF)
      |=> !t2_stop_exit_o && !t2_feedhold_o) else $error("action in off mode");
   a_reserved_ign: assert property ((servo_tick_i && (live & t2_mask_q) == 24'h00_0000)
      |=> !t2_hit_q) else $error("reserved bit acted");
   a_plus_block: assert property ((move_i.valid && move_i.positive && plus_d)
      |=> !move_grant_o) else $error("positive move passed");
   a_minus_free: assert property ((move_i.valid && !move_i.positive && !minus_d)
      |=> move_grant_o) else $error("negative move refused");
   a_minus_block: assert property ((move_i.valid && !move_i.positive && minus_d)
      |=> !move_grant_o) else $error("negative move passed");
   a_cmd_limit: assert property (g_pool[0].used1_q <= split_q[0][8:0]
      || $past(task_clear_i[0])) else $error("cmd pool overrun");
   a_ext_count: assert property ((take && line_i.has_ref && !line_i.task2
      && !task_clear_i[0]) |=> g_pool[1].used1_q == $past(g_pool[1].used1_q) + 9'h001)
      else $error("ext buffer not used");
   a_srv_delay: assert property ((dly_q == FMR_DLY_WAIT && !sys_reset_i
      && pre_q == 32'h0000_0000 && ms_left_q <= 24'h00_0001) |=> ##1 servo_reset_o)
      else $error("servo reset late");
   // Hold rises at the same edge that samples the reset command
   a_srv_hold: assert property ($rose(servo_hold_o) |-> $past(sys_reset_i))
      else $error("hold without reset");

   c_exit: cover property (t2_stop_exit_o);
   c_hold: cover property (t2_feedhold_o && plus_inhibit_o);
   c_pool_full: cover property (line_fail_o);
   c_srv_reset: cover property (servo_reset_o);
endmodule
`default_nettype wire

// ==== fmr_traj_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module fmr_traj_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Requests from the bench
   input wire logic want_i,
   input wire logic pos_i,
   // Servo side
   output fmr_pkg::fmr_move_t move_o,
   output logic tick_o
);
   import fmr_pkg::*;
   logic [1:0] cnt_q; // Servo update divider
   // Servo update every four cycles; an idle request flips its direction bit
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cnt_q <= 2'h0;
         tick_o <= 1'b0;
         move_o <= '0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
         tick_o <= (cnt_q == 2'h3);
         move_o.valid <= want_i;
         move_o.positive <= want_i ? pos_i : ~move_o.positive;
      end
   end
endmodule
`default_nettype wire

// ==== fault_mask_response_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fmr_defines.svh"
module fault_mask_response_tb;
   import fmr_pkg::*;
   logic clk = 0, rst_n = 0, rd = 0, wr = 0, sysr = 0, want = 0, pos = 0;
   logic [13:0] addr = '0;
   logic [31:0] wdata = '0, rdata, q;
   logic [23:0] fault = '0, rate;
   logic [1:0] tclr = '0;
   fmr_line_t line = '0;
   fmr_move_t mv;
   logic tick, wreq, grant, sx, fh, pi, mi, lok, lfl, hold, srst, irq;
   int n_fail = 0, compares = 0;
   int c_sx, c_fh, c_pi, c_mi, c_gr, c_ok, c_fl, c_sr, c_hd;
   // Clock at 100 MHz
   initial forever #5 clk = ~clk;
   fmr_top #(.MS_CYCLES(4)) u_dut (.ref_clk_i(clk), .rst_n_i(rst_n),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .fault_status_i(fault),
      .servo_tick_i(tick), .sys_reset_i(sysr), .move_i(mv), .move_grant_o(grant),
      .t2_stop_exit_o(sx), .t2_feedhold_o(fh), .t2_feedhold_rate_o(rate),
      .plus_inhibit_o(pi), .minus_inhibit_o(mi), .line_i(line), .task_clear_i(tclr),
      .line_ok_o(lok), .line_fail_o(lfl), .servo_hold_o(hold), .servo_reset_o(srst),
      .irq_o(irq));
   fmr_traj_model u_traj (.clk_i(clk), .rst_n_i(rst_n), .want_i(want), .pos_i(pos),
      .move_o(mv), .tick_o(tick));
   // Verdict and end of run
   task automatic end_sim();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One Avalon access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [11:0] idx, input logic [23:0] d,
                      output logic [31:0] r);
      int n;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= {idx, 2'b00};
      wdata <= {8'h00, d};
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         #1;
         if (wreq === 1'b0) break;
      end
      if (n == 50) begin
         n_fail++;
         end_sim();
      end
      // Read data already stands for the completing edge
      r = rdata;
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic wreg(input logic [11:0] idx, input logic [23:0] d);
      bus(1'b1, idx, d, q);
   endtask
   task automatic rreg(input logic [11:0] idx, input logic [23:0] e);
      bus(1'b0, idx, 24'h00_0000, q);
      chk(q, {8'h00, e});
   endtask
   // Counts output activity over n cycles, starting in the current cycle
   task automatic run(input int n);
      {c_sx, c_fh, c_pi, c_mi, c_gr, c_ok, c_fl, c_sr, c_hd} = '0;
      repeat (n) begin
         #1;
         c_sx += (sx === 1'b1);
         c_fh += (fh === 1'b1);
         c_pi += (pi === 1'b1);
         c_mi += (mi === 1'b1);
         c_gr += (grant === 1'b1);
         c_ok += (lok === 1'b1);
         c_fl += (lfl === 1'b1);
         c_sr += (srst === 1'b1);
         c_hd += (hold === 1'b1);
         @(posedge clk);
      end
   endtask
   task automatic setf(input logic [23:0] v);
      @(posedge clk);
      fault <= v;
      run(12);
   endtask
   task automatic offer(input logic t2, input logic rf, input logic st);
      @(posedge clk);
      line <= '{valid: 1'b1, task2: t2, has_ref: rf, has_string: st};
      @(posedge clk);
      line <= '0;
      run(2);
   endtask
   // Reset values, then an unmapped read
   task automatic t_reset();
      logic [11:0] ix [8] = '{`FMR_IDX_T2_MASK, `FMR_IDX_PLUS_MASK, `FMR_IDX_MINUS_MASK,
         `FMR_IDX_CMD_SPLIT, `FMR_IDX_EXT_SPLIT, `FMR_IDX_STR_SPLIT, `FMR_IDX_SRV_DELAY,
         `FMR_IDX_IRQ_MASK};
      logic [23:0] ev [8] = '{24'h02_9b01, 24'h00_0100, 24'h00_0100, 24'h00_00fa,
         24'h00_0028, 24'h00_0028, 24'h00_07d0, 24'h00_0000};
      for (int i = 0; i < 8; i++)
         rreg(ix[i], ev[i]);
      rreg(12'h3ff, 24'h00_0000);
   endtask
   // Each exception mode against a standing masked fault
   task automatic t_modes();
      wreg(`FMR_IDX_T2_MASK, 24'h00_1000);
      wreg(`FMR_IDX_T2_RATE, 24'h00_1234);
      for (int m = 0; m < 3; m++) begin
         wreg(`FMR_IDX_T2_MODE, m[23:0]);
         setf(24'h00_1000);
         chk(c_sx, (m == 2));
         chk(c_fh != 0, (m == 1));
         chk(rate, 32'h0000_1234);
         setf(24'h00_0000);
      end
      wreg(`FMR_IDX_T2_MODE, 24'h00_0003);
      rreg(`FMR_IDX_T2_MODE, 24'h00_0002);
      wreg(`FMR_IDX_T2_MODE, 24'h00_0001);
      wreg(`FMR_IDX_T2_MASK, 24'h00_0400);
      rreg(`FMR_IDX_T2_MASK, 24'h00_0400);
      setf(24'h00_0400);
      chk(c_fh, 0);
      setf(24'h00_0000);
   endtask
   // Direction inhibits block one direction only
   task automatic t_dir();
      wreg(`FMR_IDX_MINUS_MASK, 24'h00_0000);
      setf(24'h00_0100);
      chk(c_pi != 0, 1);
      chk(c_mi, 0);
      want <= 1'b1;
      pos <= 1'b1;
      run(8);
      chk(c_gr, 0);
      pos <= 1'b0;
      run(8);
      chk(c_gr != 0, 1);
      wreg(`FMR_IDX_PLUS_MASK, 24'h00_0000);
      wreg(`FMR_IDX_MINUS_MASK, 24'h00_0100);
      // Masks only take effect at the next servo update
      run(5);
      run(8);
      chk(c_gr, 0);
      pos <= 1'b1;
      run(8);
      chk(c_gr != 0, 1);
      want <= 1'b0;
      setf(24'h00_0000);
      chk(c_pi + c_mi < 12, 1);
   endtask
   // Split one pool to leave one slot, then take it twice
   task automatic pool2(input logic [11:0] ix, input logic [23:0] v, input logic t2,
                        input logic rf, input logic st);
      wreg(ix, v);
      @(posedge clk);
      tclr <= 2'h3;
      @(posedge clk);
      tclr <= 2'h0;
      offer(t2, rf, st);
      chk(c_ok, 1);
      offer(t2, rf, st);
      chk(c_ok, 0);
      chk(c_fl, 1);
   endtask
   task automatic t_pool();
      pool2(`FMR_IDX_CMD_SPLIT, 24'h00_0001, 1'b0, 1'b0, 1'b0);
      pool2(`FMR_IDX_CMD_SPLIT, 24'h00_012b, 1'b1, 1'b0, 1'b0);
      wreg(`FMR_IDX_CMD_SPLIT, 24'h00_00fa);
      pool2(`FMR_IDX_EXT_SPLIT, 24'h00_0001, 1'b0, 1'b1, 1'b0);
      pool2(`FMR_IDX_EXT_SPLIT, 24'h00_0031, 1'b1, 1'b1, 1'b0);
      pool2(`FMR_IDX_STR_SPLIT, 24'h00_0001, 1'b0, 1'b0, 1'b1);
      pool2(`FMR_IDX_STR_SPLIT, 24'h00_0031, 1'b1, 1'b0, 1'b1);
      wreg(`FMR_IDX_CMD_SPLIT, 24'h00_012c);
      rreg(`FMR_IDX_CMD_SPLIT, 24'h00_00fa);
      wreg(`FMR_IDX_EXT_SPLIT, 24'h00_0032);
      rreg(`FMR_IDX_EXT_SPLIT, 24'h00_0031);
   endtask
   // Servo reset delay, its interrupt, and clearing it by a status read
   task automatic t_servo();
      bus(1'b0, `FMR_IDX_IRQ_STAT, 24'h00_0000, q);
      wreg(`FMR_IDX_IRQ_MASK, 24'h00_0008);
      for (int d = 1; d < 3; d++) begin
         wreg(`FMR_IDX_SRV_DELAY, d[23:0]);
         @(posedge clk);
         sysr <= 1'b1;
         @(posedge clk);
         sysr <= 1'b0;
         run(d * 4 + 6);
         chk(c_sr, 1);
         chk(c_hd, d * 4);
         chk(irq, 1'b1);
      end
      rreg(`FMR_IDX_IRQ_STAT, 24'h00_0008);
      run(2);
      chk(irq, 1'b0);
      wreg(`FMR_IDX_SRV_DELAY, 24'h00_2711);
      rreg(`FMR_IDX_SRV_DELAY, 24'h00_0002);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_modes();
      t_dir();
      t_pool();
      t_servo();
      end_sim();
   end
   initial begin
      #500000;
      n_fail++;
      end_sim();
   end
endmodule
`default_nettype wire
